/* fes_ctrl.sv */
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Operation
// - window flag read before and after each added sector command.
// - status checked by at least two reads in a row.
// - with timeout high, re-check toggle; still toggling issues reset.
// - every poll start or restart begins with a fresh double read.
module fes_ctrl (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // avalon-mm slave
  input  wire logic [2:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // flash pins
  output logic      [fes_pkg::ADDR_W-1:0] flash_addr,
  output logic                            flash_ce_n,
  output logic                            flash_oe_n,
  output logic                            flash_we_n,
  input  wire logic [fes_pkg::DQ_W-1:0]   flash_dq_i,
  output logic      [fes_pkg::DQ_W-1:0]   flash_dq_o,
  output logic                            flash_dq_oe,
  input  wire logic                       ready_busy_output
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_STEP, S_WR_LO, S_WR_HI, S_RD_LO, S_RD_HI, S_ADV
  } fes_st_t;

  typedef struct packed {
    fes_st_t                    st;
    fes_pkg::fes_op_t           op;
    logic [2:0]                 idx;
    logic [fes_pkg::CNT_W-1:0]  cnt;
    logic                       pollph;
    logic                       pair;
    logic                       recheck;
    logic                       busy;
    logic                       done;
    logic                       fail;
    logic                       rej;
    logic                       winpre;
    logic [fes_pkg::ADDR_W-1:0] uaddr;
    logic [fes_pkg::DQ_W-1:0]   wdata;
    logic [fes_pkg::DQ_W-1:0]   first;
    logic [fes_pkg::DQ_W-1:0]   last;
    logic [fes_pkg::DQ_W-1:0]   rdata;
    logic [fes_pkg::DQ_W-1:0]   dq_s1;
    logic [fes_pkg::DQ_W-1:0]   dq_s2;
    logic                       rb_s1;
    logic                       rb_s2;
    logic [fes_pkg::ADDR_W-1:0] addr;
    logic                       ce_n;
    logic                       oe_n;
    logic                       we_n;
    logic [fes_pkg::DQ_W-1:0]   dq_o;
    logic                       dq_oe;
    logic                       wq;
    logic [31:0]                rdbus;
  } fes_state_t;

  fes_state_t s_q;
  fes_state_t s_d;

  // ----------------------------------------
  // command sequence table
  // ----------------------------------------
  function automatic fes_pkg::fes_step_t seq_step(fes_pkg::fes_op_t op, logic [2:0] idx);
    fes_pkg::fes_step_t t;
    t = '0;
    t.a2 = idx[0];
    t.data = idx[0] ? fes_pkg::CMD_UNLK2 : fes_pkg::CMD_UNLK1;
    case (op)
      fes_pkg::OP_PROG: begin
        if (idx == 3'h2) t.data = fes_pkg::CMD_PROG;
        if (idx == 3'h3) begin
          t.last = 1'b1;
          t.ua = 1'b1;
          t.ud = 1'b1;
          t.a2 = 1'b0;
        end
      end
      fes_pkg::OP_SERASE, fes_pkg::OP_CERASE: begin
        if (idx == 3'h2) t.data = fes_pkg::CMD_ERASE;
        if (idx == 3'h5) begin
          t.last = 1'b1;
          t.a2 = 1'b0;
          t.ua = (op == fes_pkg::OP_SERASE);
          t.data = t.ua ? fes_pkg::CMD_SECTOR : fes_pkg::CMD_CHIP;
        end
      end
      fes_pkg::OP_ADDSEC: begin
        t.ua = 1'b1;
        t.a2 = 1'b0;
        t.rd = (idx != 3'h1);
        t.last = (idx == 3'h2);
        t.data = fes_pkg::CMD_SECTOR;
      end
      fes_pkg::OP_RSTCMD: begin
        t.last = 1'b1;
        t.a2 = 1'b0;
        t.data = fes_pkg::CMD_RESET;
      end
      default: begin
        t.rd = 1'b1;
        t.last = 1'b1;
        t.ua = 1'b1;
      end
    endcase
    return t;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    fes_pkg::fes_step_t stp;
    stp = seq_step(s_q.op, s_q.idx);
    s_d = s_q;
    s_d.dq_s1 = flash_dq_i;
    s_d.dq_s2 = s_q.dq_s1;
    s_d.rb_s1 = ready_busy_output;
    s_d.rb_s2 = s_q.rb_s1;
    s_d.wq = 1'b1;
    if (s_q.cnt != '0) s_d.cnt = s_q.cnt - 1'b1;

    case (s_q.st)
      S_IDLE: begin
        s_d.cnt = '0;
      end
      S_STEP: begin
        s_d.ce_n = 1'b0;
        if (s_q.pollph || stp.rd) begin
          // status reads target the user address
          s_d.addr = s_q.uaddr;
          s_d.oe_n = 1'b0;
          s_d.cnt = fes_pkg::ACC_CYC;
          s_d.st = S_RD_LO;
        end else begin
          s_d.addr = stp.ua ? s_q.uaddr : (stp.a2 ? fes_pkg::UNLOCK_A2 : fes_pkg::UNLOCK_A1);
          s_d.dq_o = stp.ud ? s_q.wdata : {8'h00, stp.data};
          s_d.dq_oe = 1'b1;
          s_d.we_n = 1'b0;
          s_d.cnt = fes_pkg::WP_CYC;
          s_d.st = S_WR_LO;
        end
      end
      S_WR_LO: begin
        if (s_q.cnt == '0) begin
          s_d.we_n = 1'b1;
          s_d.ce_n = 1'b1;
          s_d.cnt = fes_pkg::WPH_CYC;
          s_d.st = S_WR_HI;
        end
      end
      S_WR_HI: begin
        if (s_q.cnt == '0) begin
          s_d.dq_oe = 1'b0;
          s_d.st = S_ADV;
        end
      end
      S_RD_LO: begin
        if (s_q.cnt == '0) begin
          s_d.last = s_q.dq_s2;
          // both strobes released so every read counts as new
          s_d.oe_n = 1'b1;
          s_d.ce_n = 1'b1;
          s_d.cnt = fes_pkg::OEH_CYC;
          s_d.st = S_RD_HI;
        end
      end
      S_RD_HI: begin
        if (s_q.cnt == '0) s_d.st = S_ADV;
      end
      S_ADV: begin
        s_d.st = S_STEP;
        if (s_q.pollph) begin
          if (!s_q.pair) begin
            s_d.first = s_q.last;
            s_d.pair = 1'b1;
          end else if (s_q.first[fes_pkg::BIT_TOGGLE] == s_q.last[fes_pkg::BIT_TOGGLE]) begin
            // steady toggle bit: operation over
            s_d.rdata = s_q.last;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.pollph = 1'b0;
            s_d.st = S_IDLE;
          end else if (s_q.recheck) begin
            // locked in algorithm: reset command back to array reads
            s_d.fail = 1'b1;
            s_d.pollph = 1'b0;
            s_d.op = fes_pkg::OP_RSTCMD;
            s_d.idx = '0;
          end else begin
            // still toggling: new pair, which decides only if the timeout flag was seen
            s_d.recheck = s_q.last[fes_pkg::BIT_TIMEOUT];
            s_d.pair = 1'b0;
          end
        end else if (stp.last) begin
          if (stp.rd) s_d.rdata = s_q.last;
          if (s_q.op == fes_pkg::OP_ADDSEC) begin
            s_d.rej = s_q.last[fes_pkg::BIT_WINDOW];
          end
          if (s_q.op == fes_pkg::OP_PROG || s_q.op == fes_pkg::OP_SERASE ||
              s_q.op == fes_pkg::OP_CERASE) begin
            s_d.pollph = 1'b1;
            s_d.pair = 1'b0;
            s_d.recheck = 1'b0;
          end else begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st = S_IDLE;
          end
        end else begin
          if (s_q.op == fes_pkg::OP_ADDSEC) begin
            s_d.winpre = s_q.last[fes_pkg::BIT_WINDOW];
          end
          s_d.idx = s_q.idx + 3'h1;
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    // avalon slave: one wait cycle, write applied when waitrequest is low
    if (s_q.wq && (avs_read || avs_write)) begin
      s_d.wq = 1'b0;
      case (avs_address)
        fes_pkg::REG_ADDR:   s_d.rdbus = 32'(s_q.uaddr);
        fes_pkg::REG_WDATA:  s_d.rdbus = 32'(s_q.wdata);
        fes_pkg::REG_STATUS: begin
          s_d.rdbus = '0;
          s_d.rdbus[fes_pkg::ST_BUSY_BIT] = s_q.busy;
          s_d.rdbus[fes_pkg::ST_DONE_BIT] = s_q.done;
          s_d.rdbus[fes_pkg::ST_FAIL_BIT] = s_q.fail;
          s_d.rdbus[fes_pkg::ST_REJ_BIT] = s_q.rej;
          s_d.rdbus[fes_pkg::ST_RB_BIT] = s_q.rb_s2;
          s_d.rdbus[fes_pkg::ST_WINPRE_BIT] = s_q.winpre;
          s_d.rdbus[fes_pkg::ST_BYTE_LSB +: 8] = s_q.last[7:0];
        end
        fes_pkg::REG_RDATA:  s_d.rdbus = 32'(s_q.rdata);
        default:             s_d.rdbus = '0;
      endcase
    end
    if (!s_q.wq && avs_write) begin
      case (avs_address)
        fes_pkg::REG_CTRL: begin
          if (avs_writedata[fes_pkg::CTRL_STOP_BIT]) begin
            s_d.st = S_IDLE;
            s_d.busy = 1'b0;
            s_d.pollph = 1'b0;
            s_d.ce_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.we_n = 1'b1;
            s_d.dq_oe = 1'b0;
          end else if (!s_q.busy && avs_writedata[2:0] <= 3'(fes_pkg::OP_POLL)) begin
            s_d.op = fes_pkg::fes_op_t'(avs_writedata[2:0]);
            s_d.idx = '0;
            s_d.busy = 1'b1;
            s_d.done = 1'b0;
            s_d.fail = 1'b0;
            s_d.rej = 1'b0;
            s_d.winpre = 1'b0;
            s_d.pollph = (avs_writedata[2:0] == 3'(fes_pkg::OP_POLL));
            s_d.pair = 1'b0;
            s_d.recheck = 1'b0;
            s_d.st = S_STEP;
          end
        end
        fes_pkg::REG_ADDR:  if (!s_q.busy) s_d.uaddr = avs_writedata[fes_pkg::ADDR_W-1:0];
        fes_pkg::REG_WDATA: if (!s_q.busy) s_d.wdata = avs_writedata[fes_pkg::DQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.op <= fes_pkg::OP_READ;
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.wq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign avs_readdata    = s_q.rdbus;
  assign avs_waitrequest = s_q.wq;
  assign flash_addr      = s_q.addr;
  assign flash_ce_n      = s_q.ce_n;
  assign flash_oe_n      = s_q.oe_n;
  assign flash_we_n      = s_q.we_n;
  assign flash_dq_o      = s_q.dq_o;
  assign flash_dq_oe     = s_q.dq_oe;

endmodule

/* fes_pkg.sv */
package fes_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 21;
  localparam int DQ_W   = 16;
  localparam int CNT_W  = 8;

  // ----------------------------------------
  // software register map (word index)
  // ----------------------------------------
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_WDATA  = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA  = 3'h4;
  localparam int CTRL_STOP_BIT  = 7;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_FAIL_BIT    = 2;
  localparam int ST_REJ_BIT     = 3;
  localparam int ST_RB_BIT      = 4;
  localparam int ST_WINPRE_BIT  = 5;
  localparam int ST_BYTE_LSB    = 8;

  // ----------------------------------------
  // device status bit positions
  // ----------------------------------------
  localparam int BIT_TOGGLE  = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_WINDOW  = 3;

  // ----------------------------------------
  // operations and command bytes
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_SERASE, OP_CERASE, OP_ADDSEC, OP_RSTCMD, OP_POLL
  } fes_op_t;

  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 21'h0002AA;
  localparam logic [7:0] CMD_UNLK1  = 8'hAA;
  localparam logic [7:0] CMD_UNLK2  = 8'h55;
  localparam logic [7:0] CMD_PROG   = 8'hA0;
  localparam logic [7:0] CMD_ERASE  = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_CHIP   = 8'h10;
  localparam logic [7:0] CMD_RESET  = 8'hF0;

  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  localparam int CLK_NS   = 4;
  localparam int T_WP_NS  = 35;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 100;
  localparam int T_OEH_NS = 20;
  localparam int SYNC_CYC = 2;
  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WPH_CYC = CNT_W'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [CNT_W-1:0] OEH_CYC = CNT_W'((T_OEH_NS + CLK_NS - 1) / CLK_NS);

  // one step of a command sequence
  typedef struct packed {
    logic       rd;
    logic       last;
    logic       ua;
    logic       ud;
    logic       a2;
    logic [7:0] data;
  } fes_step_t;

endpackage

/* fes_ctrl_monitor.sv */
`timescale 1ns/1ps

module fes_ctrl_monitor (
  // clock and reset
  input wire logic                       ref_clk,
  input wire logic                       rst,
  // register bus
  input wire logic [2:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  // flash pins
  input wire logic [fes_pkg::ADDR_W-1:0] flash_addr,
  input wire logic                       flash_ce_n,
  input wire logic                       flash_oe_n,
  input wire logic                       flash_we_n,
  input wire logic [fes_pkg::DQ_W-1:0]   flash_dq_o,
  input wire logic                       flash_dq_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // flash cycle steps
  // ----------------------------------------
  sequence s_wr;
    !flash_we_n && !flash_ce_n && flash_dq_oe;
  endsequence
  sequence s_off;
    flash_ce_n && flash_oe_n && flash_we_n;
  endsequence

  chk_wait_once: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after a request");
  chk_wait_pulse: assert property (
    !avs_waitrequest |-> (avs_read || avs_write) ##1 avs_waitrequest)
    else $error("waitrequest low without a request or too long");
  chk_read_zero: assert property (avs_read && !avs_waitrequest
    && (avs_address == fes_pkg::REG_CTRL || avs_address > fes_pkg::REG_RDATA)
    |-> avs_readdata == 32'h0)
    else $error("write-only or unmapped register read not zero");
  chk_write_pulse: assert property (
    $fell(flash_we_n) |-> s_wr[*8] ##1 s_wr[*2] ##1 flash_we_n)
    else $error("write pulse not ten cycles wide");
  chk_read_gap: assert property (
    $rose(flash_oe_n) |-> s_off[*5])
    else $error("read strobes not released for five cycles");
  chk_no_clash: assert property (
    !flash_we_n |-> flash_oe_n && flash_dq_oe)
    else $error("write pulse overlaps output enable");
  chk_read_quiet: assert property (
    !flash_oe_n && !$past(flash_oe_n) |-> $stable(flash_addr) && !flash_ce_n && !flash_dq_oe)
    else $error("address or strobes moved inside a read");
  chk_write_hold: assert property (
    !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_o) && $stable(flash_addr))
    else $error("data or address moved inside a write pulse");
endmodule

bind fes_ctrl fes_ctrl_monitor u_mon (.*);

/* fes_flash_model.sv */
`timescale 1ns/1ps

module fes_flash_model #(
  parameter int PROG_READS  = 5,
  parameter int ERASE_READS = 12,
  parameter int WIN_READS   = 4
) (
  // host-driven pins
  input  wire logic                       ce_n,
  input  wire logic                       oe_n,
  input  wire logic                       we_n,
  input  wire logic [fes_pkg::ADDR_W-1:0] addr,
  input  wire logic [fes_pkg::DQ_W-1:0]   dq_in,
  input  wire logic                       dq_oe,
  // device-driven pins
  output logic      [fes_pkg::DQ_W-1:0]   dq_out,
  output logic                            rb_low,
  // scenario knobs
  input  wire logic                       lock,
  input  wire logic                       protect,
  output int                              n_rst_cmd
);
  logic [15:0] arr [logic [20:0]];
  logic [7:0]  cmd [0:5];
  logic [15:0] cur = 16'hFFFF;
  logic        busy = 1'b0;
  logic        erase = 1'b0;
  logic        tog = 1'b0;
  logic        stog = 1'b0;
  logic        win = 1'b0;
  logic        b7 = 1'b0;
  logic        wr_arm = 1'b0;
  int          nw = 0;
  int          left = 0;
  int          rds = 0;

  initial n_rst_cmd = 0;
  assign rb_low = busy;
  // released lines show the inverse of the last value
  assign dq_out = (!ce_n && !oe_n && !dq_oe) ? cur : ~cur;

  task automatic begin_op(input logic e, input int n);
    erase = e;
    left = n;
    rds = 0;
    nw = 0;
    win = 1'b0;
    busy = 1'b1;
  endtask

  // write ends on whichever of ce_n or we_n rises first
  always @(negedge (ce_n | we_n)) wr_arm = oe_n;

  always @(posedge (ce_n | we_n)) begin
    if (wr_arm) begin
      wr_arm = 1'b0;
      if (dq_in[7:0] == fes_pkg::CMD_RESET) begin
        busy = 1'b0;
        nw = 0;
        n_rst_cmd = n_rst_cmd + 1;
      end else if (!busy) begin // other commands ignored while busy
        cmd[nw] = dq_in[7:0];
        if (nw == 3 && cmd[2] == fes_pkg::CMD_PROG) begin
          if (!protect) arr[addr] = dq_in;
          b7 = dq_in[7];
          begin_op(1'b0, PROG_READS);
        end else if (nw == 5) begin
          if (!protect) arr.delete();
          begin_op(1'b1, ERASE_READS);
        end else begin
          nw = nw + 1;
        end
      end
    end
  end

  // the later of ce_n and oe_n falling (both low) starts a new read
  always @(negedge (ce_n | oe_n)) begin
    if (busy) begin
      rds = rds + 1;
      tog = ~tog;
      stog = erase ? ~stog : 1'b1;
      win = erase && rds >= WIN_READS;
      if (!lock) left = left - 1; // stuck program never ends
      if (left == 0) busy = 1'b0;
    end
    if (busy) begin
      cur = {8'h00, erase ? 1'b0 : ~b7, tog, lock && rds >= 2,
             1'b0, win, stog, 2'b00};
    end else begin
      cur = arr.exists(addr) ? arr[addr] : 16'hFFFF;
    end
  end
endmodule

/* fes_ctrl_tb.sv */
`timescale 1ns/1ps

module fes_ctrl_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int              LIMIT = 40000;
  logic                       ref_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [2:0]                 avs_address = 3'h0;
  logic                       avs_read = 1'b0;
  logic                       avs_write = 1'b0;
  logic [31:0]                avs_writedata = 32'h0;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic [fes_pkg::ADDR_W-1:0] flash_addr;
  logic                       flash_ce_n;
  logic                       flash_oe_n;
  logic                       flash_we_n;
  logic [fes_pkg::DQ_W-1:0]   flash_dq_i;
  logic [fes_pkg::DQ_W-1:0]   flash_dq_o;
  logic                       flash_dq_oe;
  logic                       ready_busy_output;
  logic                       rb_low;
  logic                       lock = 1'b0;
  logic                       protect = 1'b0;
  logic [31:0]                q;
  int                         n_rst;
  int                         n_mismatch = 0;
  int                         n_compared = 0;
  int                         cyc = 0;

  fes_ctrl dut (.*);
  fes_flash_model u_flash (
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .addr(flash_addr),
    .dq_in(flash_dq_o), .dq_oe(flash_dq_oe), .dq_out(flash_dq_i), .rb_low(rb_low),
    .lock(lock), .protect(protect), .n_rst_cmd(n_rst));
  // open drain with pull-up
  assign ready_busy_output = ~rb_low;
  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input string what, input logic [2:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, q, exp);
  endtask

  task automatic start(input fes_pkg::fes_op_t op);
    bus(1'b1, fes_pkg::REG_CTRL, {29'h0, op});
  endtask

  task automatic wait_idle;
    do bus(1'b0, fes_pkg::REG_STATUS, 32'h0); while (q[fes_pkg::ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic wait_rb;
    do bus(1'b0, fes_pkg::REG_STATUS, 32'h0); while (q[fes_pkg::ST_RB_BIT] !== 1'b0);
    chk("busy_while_rb_low", {31'h0, q[fes_pkg::ST_BUSY_BIT]}, 32'h1);
  endtask

  task automatic run(input fes_pkg::fes_op_t op);
    start(op);
    wait_idle;
  endtask

  task automatic prog(input logic [15:0] d);
    bus(1'b1, fes_pkg::REG_ADDR, 32'h0001_2340);
    bus(1'b1, fes_pkg::REG_WDATA, {16'h0, d});
    start(fes_pkg::OP_PROG);
    wait_rb;
    wait_idle;
  endtask

  task automatic erase_add(input fes_pkg::fes_op_t op, input int n, input logic [31:0] exp);
    start(op);
    wait_rb;
    bus(1'b1, fes_pkg::REG_CTRL, 32'h80);
    wait_idle;
    repeat (n) run(fes_pkg::OP_READ);
    run(fes_pkg::OP_ADDSEC);
    bus(1'b0, fes_pkg::REG_STATUS, 32'h0);
    chk("window_flags", q & 32'h28, exp);
    run(fes_pkg::OP_POLL);
    rd_chk("erased_data", fes_pkg::REG_RDATA, 32'hFFFF);
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_sim;
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd_chk("status_reset", fes_pkg::REG_STATUS, 32'h10);
    rd_chk("unmapped", 3'h7, 32'h0);
    prog(16'h5A3C);
    rd_chk("prog_status", fes_pkg::REG_STATUS, 32'h3C12);
    rd_chk("prog_data", fes_pkg::REG_RDATA, 32'h5A3C);
    rd_chk("addr_back", fes_pkg::REG_ADDR, 32'h0001_2340);
    protect <= 1'b1;
    prog(16'h0000);
    protect <= 1'b0;
    run(fes_pkg::OP_READ);
    rd_chk("protected_data", fes_pkg::REG_RDATA, 32'h5A3C);
    erase_add(fes_pkg::OP_SERASE, 0, 32'h0);
    erase_add(fes_pkg::OP_CERASE, 3, 32'h28);
    run(fes_pkg::OP_RSTCMD);
    chk("reset_cmds", 32'(n_rst), 32'h1);
    lock <= 1'b1;
    prog(16'h1234);
    bus(1'b0, fes_pkg::REG_STATUS, 32'h0);
    chk("lock_status", q & 32'h2007, 32'h2006);
    chk("lock_reset", 32'(n_rst), 32'h2);
    end_sim;
  end
endmodule
